// >>> spicc_pkg.sv
package spicc_pkg;

  // register byte offsets on the peripheral bus
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h0C;
  localparam logic [7:0] OFF_IEN_CLR = 8'h14;
  localparam logic [7:0] OFF_FLAGS = 8'h18;
  localparam logic [7:0] OFF_SYNC = 8'h1C;
  localparam logic [7:0] OFF_MATCH = 8'h24;
  localparam logic [7:0] OFF_IEN_SET = 8'h40;
  localparam logic [7:0] OFF_STATUS = 8'h44;

  // control_a fields
  localparam int A_SOFT_RESET = 0;
  localparam int A_ENABLE = 1;
  localparam int A_MODE_LO = 2;
  localparam int A_CPHA = 28;
  localparam int A_CPOL = 29;
  localparam int A_FRAME_FORMAT_LO = 24;
  localparam logic [31:0] CTRL_A_WMASK = 32'h7F33019C;

  // control_b fields
  localparam int B_CHAR_SIZE_LO = 0;
  localparam int B_PRELOAD = 6;
  localparam int B_SEL_DETECT = 9;
  localparam int B_HW_SELECT = 13;
  localparam int B_MATCH_MODE_LO = 14;
  localparam int B_RX_ON = 17;
  localparam logic [31:0] CTRL_B_WMASK = 32'h0000E247;

  // sync busy, flag, status and match fields
  localparam int S_SOFT_RESET = 0;
  localparam int S_ENABLE = 1;
  localparam int S_CONTROL_B = 2;
  localparam int F_SEL_LOW = 3;
  localparam int ST_OVF = 2;
  localparam int M_VALUE_LO = 0;
  localparam int M_BOUND_LO = 16;
  localparam logic [7:0] IEN_MASK = 8'h8F;

  // reset values
  localparam logic [31:0] CTRL_A_RST = 32'h00000000;
  localparam logic [31:0] CTRL_B_RST = 32'h00000000;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [31:0] MATCH_RST = 32'h00000000;

  // field encodings
  localparam logic [2:0] MODE_CLIENT = 3'h2;
  localparam logic [2:0] MODE_HOST = 3'h3;
  localparam logic [3:0] FRAME_FORMAT_ADDR = 4'h2;
  localparam logic [2:0] CHAR_9BIT = 3'h1;
  localparam logic [3:0] BITS_8 = 4'h7;
  localparam logic [3:0] BITS_9 = 4'h8;

  typedef enum logic [1:0] {
    MATCH_MASKED = 2'b00,
    MATCH_TWO = 2'b01,
    MATCH_RANGE = 2'b10
  } spicc_match_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_ADDR = 2'b01,
    RX_DATA = 2'b10,
    RX_SKIP = 2'b11
  } spicc_rx_e;

endpackage

// >>> spicc_ctrl.sv
`timescale 1ns/10ps

// Notes on behaviour
// - enable reads back at once, busy until done
// - soft reset clears registers and disables unit
// - soft reset write drops other written bits
// - writes error, reads reset values during reset
// - reset bit and busy flag clear together
// - receiver off flushes buffer, drops overflow status
// - receiver on while disabled sets immediately
// - receiver on while enabled waits, busy meanwhile
// - mask mode compares only unmasked address bits
// - two address mode accepts either value
// - range mode accepts bound_b to value inclusive
// - address mode only for client address frames
// - hardware select drive controls select output
// - select falling edge detected when enabled
// - preload moves data to shifter while deselected
// - character size 8 or 9 bits
// - baud value sets serial clock rate
// - enable clear write one disables, both views
// - enable bits at 7,3,2,1,0
// - control_b protected; receiver enable exempt
// - mode 2 client, mode 3 host
// - select falling edge sets select-low flag
module spicc_ctrl
  import spicc_pkg::*;
(
  // bus clock domain
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_protect,
  output logic [7:0] irq_enables,
  // core clock domain
  input wire logic core_clock,
  input wire logic core_rst,
  // client pins
  input wire logic select_in_n,
  input wire logic sck_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe,
  // host pins
  output logic sck_out,
  output logic sck_oe,
  output logic select_out_n,
  output logic select_oe,
  input wire logic host_frame,
  // core-side data
  output logic [8:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [8:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic select_wake
);

  typedef struct packed {
    logic [31:0] ctrl_a;
    logic [31:0] ctrl_b;
    logic [7:0] baud;
    logic [31:0] match;
    logic [7:0] ien;
    logic sel_low_flag;
    logic busy_en;
    logic busy_reset;
    logic busy_b;
    logic rx_wait;
    logic pend;
    logic inflight;
    logic req_t;
    logic snap_en;
    logic snap_rx;
    logic snap_reset;
    logic ack_s1;
    logic ack_s2;
    logic sel_low_s1;
    logic sel_low_s2;
    logic sel_low_s3;
    logic ovf_s1;
    logic ovf_s2;
    logic [31:0] rdata;
  } spicc_bus_s;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack_t;
    logic en;
    logic rx;
    logic sel_s1;
    logic sel_s2;
    logic sel_prev;
    logic sck_s1;
    logic sck_s2;
    logic sck_prev;
    logic mosi_s1;
    logic mosi_s2;
    spicc_rx_e state;
    logic [3:0] bitcnt;
    logic [8:0] rx_sh;
    logic [8:0] rx_data;
    logic rx_valid;
    logic ovf;
    logic sel_low_t;
    logic wake;
    logic [8:0] tx_hold;
    logic tx_held;
    logic [8:0] tx_sh;
    logic [7:0] div_cnt;
    logic sck_o;
    logic sel_o;
  } spicc_core_s;

  spicc_bus_s b_q;
  spicc_bus_s b_d;
  spicc_core_s c_q;
  spicc_core_s c_d;

  // address compare for the client address frame
  function automatic logic addr_hit(input logic [1:0] mode, input logic [7:0] a,
                                    input logic [7:0] v, input logic [7:0] bnd);
    logic hit;
    hit = 1'b0;
    case (mode)
      MATCH_MASKED: hit = ((a ^ v) & ~bnd) == 8'h00;
      MATCH_TWO: hit = (a == v) || (a == bnd);
      MATCH_RANGE: hit = (a <= v) && (a >= bnd);
      default: hit = 1'b0; // reserved encoding never matches
    endcase
    return hit;
  endfunction

  logic access;
  logic wr;
  logic pac_reg;
  logic mapped;
  logic enabled;
  logic cfg_ok;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign enabled = b_q.ctrl_a[A_ENABLE];
  // config may change only when disabled and no snapshot is in flight
  assign cfg_ok = !enabled && !b_q.inflight;
  assign mapped = (paddr == OFF_CTRL_A) || (paddr == OFF_CTRL_B) || (paddr == OFF_BAUD)
               || (paddr == OFF_IEN_CLR) || (paddr == OFF_IEN_SET) || (paddr == OFF_FLAGS)
               || (paddr == OFF_SYNC) || (paddr == OFF_MATCH) || (paddr == OFF_STATUS);
  assign pac_reg = (paddr != OFF_FLAGS) && (paddr != OFF_SYNC) && (paddr != OFF_STATUS);

  // bus answer: single cycle, error on reset, protection or hole
  assign pready = 1'b1;
  assign pslverr = access && (!mapped || (pwrite && (b_q.busy_reset
                   || (write_protect && pac_reg))));
  assign prdata = b_q.rdata;
  assign irq_enables = b_q.ien;

  // bus domain next state
  always_comb
  begin
    b_d = b_q;
    b_d.ack_s1 = c_q.ack_t;
    b_d.ack_s2 = b_q.ack_s1;
    b_d.sel_low_s1 = c_q.sel_low_t;
    b_d.sel_low_s2 = b_q.sel_low_s1;
    b_d.sel_low_s3 = b_q.sel_low_s2;
    b_d.ovf_s1 = c_q.ovf;
    b_d.ovf_s2 = b_q.ovf_s1;
    // handshake completion
    if (b_q.inflight && (b_q.ack_s2 == b_q.req_t))
    begin
      b_d.inflight = 1'b0;
      if (!b_q.pend)
        b_d.busy_en = 1'b0;
      if (b_q.snap_reset)
      begin
        b_d.ctrl_a[A_SOFT_RESET] = 1'b0;
        b_d.busy_reset = 1'b0;
      end
      if (b_q.snap_rx && b_q.rx_wait)
      begin
        b_d.ctrl_b[B_RX_ON] = 1'b1;
        b_d.rx_wait = 1'b0;
        b_d.busy_b = 1'b0;
      end
    end
    // hardware-set flag: set wins over a clear in the same cycle
    if (wr && !pslverr && (paddr == OFF_FLAGS) && pwdata[F_SEL_LOW])
      b_d.sel_low_flag = 1'b0;
    if (b_q.sel_low_s3 != b_q.sel_low_s2)
      b_d.sel_low_flag = 1'b1;
    // register writes
    if (wr && !pslverr)
    begin
      case (paddr)
        OFF_CTRL_A:
        begin
          if (pwdata[A_SOFT_RESET])
          begin
            // soft reset wipes everything, other written bits are dropped
            b_d.ctrl_a = CTRL_A_RST;
            b_d.ctrl_a[A_SOFT_RESET] = 1'b1;
            b_d.ctrl_b = CTRL_B_RST;
            b_d.baud = BAUD_RST;
            b_d.match = MATCH_RST;
            b_d.ien = IEN_RST;
            b_d.sel_low_flag = 1'b0;
            b_d.busy_reset = 1'b1;
            b_d.busy_en = 1'b0;
            b_d.busy_b = 1'b0;
            b_d.rx_wait = 1'b0;
            b_d.pend = 1'b1;
          end
          else
          begin
            if (pwdata[A_ENABLE] != enabled)
            begin
              b_d.busy_en = 1'b1;
              b_d.pend = 1'b1;
            end
            if (cfg_ok)
              b_d.ctrl_a = pwdata & CTRL_A_WMASK;
            b_d.ctrl_a[A_ENABLE] = pwdata[A_ENABLE];
          end
        end
        OFF_CTRL_B:
        begin
          if (cfg_ok)
          begin
            b_d.ctrl_b = pwdata & CTRL_B_WMASK;
            b_d.pend = 1'b1;
          end
          if (!pwdata[B_RX_ON])
          begin
            b_d.ctrl_b[B_RX_ON] = 1'b0;
            b_d.rx_wait = 1'b0;
            b_d.busy_b = 1'b0;
            b_d.pend = 1'b1;
          end
          else if (enabled)
          begin
            b_d.ctrl_b[B_RX_ON] = b_q.ctrl_b[B_RX_ON];
            b_d.rx_wait = !b_q.ctrl_b[B_RX_ON];
            b_d.busy_b = !b_q.ctrl_b[B_RX_ON];
            b_d.pend = 1'b1;
          end
          else
          begin
            b_d.ctrl_b[B_RX_ON] = 1'b1;
            b_d.pend = 1'b1;
          end
        end
        OFF_BAUD:
          if (cfg_ok)
          begin
            b_d.baud = pwdata[7:0];
            b_d.pend = 1'b1;
          end
        OFF_MATCH:
          if (cfg_ok)
          begin
            b_d.match = pwdata & 32'h00FF00FF;
            b_d.pend = 1'b1;
          end
        OFF_IEN_CLR: b_d.ien = b_q.ien & ~(pwdata[7:0] & IEN_MASK);
        OFF_IEN_SET: b_d.ien = b_q.ien | (pwdata[7:0] & IEN_MASK);
        default: b_d.pend = b_d.pend;
      endcase
    end
    // start a snapshot when idle; snapshot fields hold still until acked
    if (b_q.pend && !b_q.inflight)
    begin
      b_d.pend = 1'b0;
      b_d.inflight = 1'b1;
      b_d.req_t = !b_q.req_t;
      b_d.snap_en = enabled;
      b_d.snap_rx = b_q.ctrl_b[B_RX_ON] || b_q.rx_wait;
      b_d.snap_reset = b_q.ctrl_a[A_SOFT_RESET];
    end
    // read data prepared in the setup phase
    b_d.rdata = 32'h00000000;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        OFF_CTRL_A: b_d.rdata = b_q.ctrl_a;
        OFF_CTRL_B: b_d.rdata = b_q.ctrl_b;
        OFF_BAUD: b_d.rdata = {24'h000000, b_q.baud};
        OFF_IEN_CLR: b_d.rdata = {24'h000000, b_q.ien};
        OFF_IEN_SET: b_d.rdata = {24'h000000, b_q.ien};
        OFF_FLAGS: b_d.rdata[F_SEL_LOW] = b_q.sel_low_flag;
        OFF_MATCH: b_d.rdata = b_q.match;
        OFF_STATUS: b_d.rdata[ST_OVF] = b_q.ovf_s2 && !b_q.busy_reset;
        OFF_SYNC:
        begin
          b_d.rdata[S_SOFT_RESET] = b_q.busy_reset;
          b_d.rdata[S_ENABLE] = b_q.busy_en;
          // config writes in flight show too, else software cannot tell they would be dropped
          b_d.rdata[S_CONTROL_B] = b_q.busy_b || b_q.pend || b_q.inflight;
        end
        default: b_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      b_q <= '0;
    else
      b_q <= b_d;
  end

  // core domain decoded config; only read while stable (disabled or enabled-protected)
  logic client;
  logic host;
  logic addr_frame;
  logic [3:0] last_bit;
  logic sel_fall;
  logic sck_rise;
  logic sck_fall;
  logic sample_edge;
  logic change_edge;
  logic in_frame;
  logic pop;
  logic [8:0] char_in;
  assign client = c_q.en && (b_q.ctrl_a[A_MODE_LO +: 3] == MODE_CLIENT);
  assign host = c_q.en && (b_q.ctrl_a[A_MODE_LO +: 3] == MODE_HOST);
  assign addr_frame = client && (b_q.ctrl_a[A_FRAME_FORMAT_LO +: 4] == FRAME_FORMAT_ADDR);
  assign last_bit = (b_q.ctrl_b[B_CHAR_SIZE_LO +: 3] == CHAR_9BIT) ? BITS_9 : BITS_8;
  assign sel_fall = c_q.sel_prev && !c_q.sel_s2;
  assign sck_rise = !c_q.sck_prev && c_q.sck_s2;
  assign sck_fall = c_q.sck_prev && !c_q.sck_s2;
  assign sample_edge = (b_q.ctrl_a[A_CPOL] ^ b_q.ctrl_a[A_CPHA]) ? sck_fall : sck_rise;
  assign change_edge = (b_q.ctrl_a[A_CPOL] ^ b_q.ctrl_a[A_CPHA]) ? sck_rise : sck_fall;
  assign in_frame = client && !c_q.sel_s2;
  assign pop = c_q.rx_valid && rx_ready;
  assign char_in = {c_q.rx_sh[7:0], c_q.mosi_s2};

  assign rx_data = c_q.rx_data;
  assign rx_valid = c_q.rx_valid;
  assign tx_ready = !c_q.tx_held;
  assign miso_out = (last_bit == BITS_9) ? c_q.tx_sh[8] : c_q.tx_sh[7];
  assign miso_oe = in_frame;
  assign sck_out = c_q.sck_o;
  assign sck_oe = host;
  assign select_out_n = c_q.sel_o;
  assign select_oe = host && b_q.ctrl_b[B_HW_SELECT];
  assign select_wake = c_q.wake;

  // core domain next state
  always_comb
  begin
    c_d = c_q;
    c_d.req_s1 = b_q.req_t;
    c_d.req_s2 = c_q.req_s1;
    c_d.req_s3 = c_q.req_s2;
    c_d.sel_s1 = select_in_n;
    c_d.sel_s2 = c_q.sel_s1;
    c_d.sel_prev = c_q.sel_s2;
    c_d.sck_s1 = sck_in;
    c_d.sck_s2 = c_q.sck_s1;
    c_d.sck_prev = c_q.sck_s2;
    c_d.mosi_s1 = mosi_in;
    c_d.mosi_s2 = c_q.mosi_s1;
    c_d.wake = 1'b0;
    if (pop)
      c_d.rx_valid = 1'b0;
    // select falling edge: wake pulse and flag event
    if (sel_fall && client && b_q.ctrl_b[B_SEL_DETECT])
    begin
      c_d.wake = 1'b1;
      c_d.sel_low_t = !c_q.sel_low_t;
    end
    // transmit side: preload straight to shifter while deselected
    if (tx_valid && !c_q.tx_held)
    begin
      if (b_q.ctrl_b[B_PRELOAD] && c_q.sel_s2)
        c_d.tx_sh = tx_data;
      else
      begin
        c_d.tx_hold = tx_data;
        c_d.tx_held = 1'b1;
      end
    end
    // receive framing
    if (sel_fall && client)
    begin
      c_d.bitcnt = 4'h0;
      c_d.rx_sh = 9'h000;
      c_d.state = addr_frame ? RX_ADDR : RX_DATA;
      if (c_q.tx_held && !b_q.ctrl_b[B_PRELOAD])
      begin
        c_d.tx_sh = c_q.tx_hold;
        c_d.tx_held = 1'b0;
      end
    end
    else if (!in_frame)
      c_d.state = RX_IDLE;
    else if (sample_edge && (c_q.state != RX_IDLE))
    begin
      c_d.rx_sh = char_in;
      c_d.bitcnt = c_q.bitcnt + 4'h1;
      if (c_q.bitcnt == last_bit)
      begin
        c_d.bitcnt = 4'h0;
        if (c_q.state == RX_ADDR)
          c_d.state = addr_hit(b_q.ctrl_b[B_MATCH_MODE_LO +: 2], char_in[7:0], b_q.match[M_VALUE_LO +: 8],
                               b_q.match[M_BOUND_LO +: 8]) ? RX_DATA : RX_SKIP;
        // push into the one-entry buffer; a full buffer drops and flags
        if (c_q.rx && (c_q.state != RX_SKIP) && (c_q.state != RX_ADDR || c_d.state == RX_DATA))
        begin
          if (c_q.rx_valid && !pop)
            c_d.ovf = 1'b1;
          else
          begin
            c_d.rx_data = (last_bit == BITS_9) ? char_in : {1'b0, char_in[7:0]};
            c_d.rx_valid = 1'b1;
          end
        end
        c_d.tx_sh = c_q.tx_held ? c_q.tx_hold : 9'h000;
        c_d.tx_held = 1'b0;
      end
    end
    else if (change_edge && (c_q.bitcnt != 4'h0))
      c_d.tx_sh = {c_q.tx_sh[7:0], 1'b0};
    // host serial clock from the baud divider
    if (host && host_frame)
    begin
      c_d.div_cnt = c_q.div_cnt + 8'h01;
      if (c_q.div_cnt == b_q.baud)
      begin
        c_d.div_cnt = 8'h00;
        c_d.sck_o = !c_q.sck_o;
      end
    end
    else
    begin
      c_d.div_cnt = 8'h00;
      c_d.sck_o = b_q.ctrl_a[A_CPOL];
    end
    c_d.sel_o = !(host && host_frame && b_q.ctrl_b[B_HW_SELECT]);
    // receiver off flushes buffer and overflow, drops frame
    if (!c_q.rx)
    begin
      c_d.rx_valid = 1'b0;
      c_d.ovf = 1'b0;
      if (c_q.state != RX_IDLE)
        c_d.state = RX_SKIP;
    end
    // apply a new snapshot from the bus side and acknowledge it
    if (c_q.req_s2 != c_q.req_s3)
    begin
      c_d.ack_t = c_q.req_s2;
      c_d.en = b_q.snap_en;
      c_d.rx = b_q.snap_rx;
      if (!b_q.snap_rx)
      begin
        c_d.rx_valid = 1'b0;
        c_d.ovf = 1'b0;
        c_d.state = RX_IDLE;
      end
      if (b_q.snap_reset)
      begin
        // soft reset of the core side, keeping the handshake toggles
        c_d.en = 1'b0;
        c_d.rx = 1'b0;
        c_d.state = RX_IDLE;
        c_d.rx_valid = 1'b0;
        c_d.ovf = 1'b0;
        c_d.tx_held = 1'b0;
        c_d.tx_sh = 9'h000;
        c_d.bitcnt = 4'h0;
      end
    end
  end

  always_ff @(posedge core_clock)
  begin
    if (core_rst)
      c_q <= '0;
    else
      c_q <= c_d;
  end

endmodule

// >>> spicc_chk.sv
`timescale 1ns/10ps
module spicc_chk
  import spicc_pkg::*;
(
  // bus domain
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic write_protect,
  input wire logic [7:0] irq_enables,
  // core domain
  input wire logic core_clock,
  input wire logic core_rst,
  input wire logic miso_oe,
  input wire logic sck_oe,
  input wire logic select_oe,
  input wire logic select_wake
);
  logic acc;
  logic [7:0] wlo;
  // access phase strobe and low data byte, shared by the bus checks
  assign acc = psel && penable;
  assign wlo = pwdata[7:0];

  AST_READY: assert property (@(posedge clock) disable iff (rst) acc |-> pready)
    else $error("access phase without ready");
  AST_IDLE_NOERR: assert property (@(posedge clock) disable iff (rst) !acc |-> !pslverr)
    else $error("error response outside access phase");
  AST_UNMAPPED: assert property (@(posedge clock) disable iff (rst) acc && paddr == 8'h08 |-> pslverr)
    else $error("unmapped address accepted");
  AST_PROTECT: assert property (@(posedge clock) disable iff (rst)
    acc && pwrite && write_protect && (paddr == OFF_CTRL_B || paddr == OFF_BAUD) |-> pslverr)
    else $error("protected write accepted");
  AST_RD_IDLE: assert property (@(posedge clock) disable iff (rst) !(psel && !penable) |=> prdata == 32'h0)
    else $error("read data outside access phase");
  AST_IEN_CLR: assert property (@(posedge clock) disable iff (rst)
    acc && pwrite && !pslverr && paddr == OFF_IEN_CLR |=> (irq_enables & $past(wlo)) == 8'h00)
    else $error("enable clear left a bit set");
  AST_IEN_SET: assert property (@(posedge clock) disable iff (rst)
    acc && pwrite && !pslverr && paddr == OFF_IEN_SET |=> (irq_enables & $past(wlo)) == ($past(wlo) & IEN_MASK))
    else $error("enable set missed a bit");
  AST_IEN_LAYOUT: assert property (@(posedge clock) disable iff (rst) irq_enables[6:4] == 3'h0)
    else $error("unused enable bits set");
  AST_ROLES: assert property (@(posedge core_clock) disable iff (core_rst) !(miso_oe && sck_oe))
    else $error("client and host drivers both on");
  AST_SEL_DRIVE: assert property (@(posedge core_clock) disable iff (core_rst) select_oe |-> sck_oe)
    else $error("select driven outside host mode");
  AST_WAKE: assert property (@(posedge core_clock) disable iff (core_rst)
    select_wake |-> !sck_oe ##1 !select_wake)
    else $error("wake pulse too long or in host mode");
endmodule

bind spicc_ctrl spicc_chk u_chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .write_protect(write_protect), .irq_enables(irq_enables), .core_clock(core_clock), .core_rst(core_rst),
  .miso_oe(miso_oe), .sck_oe(sck_oe), .select_oe(select_oe), .select_wake(select_wake));

// >>> spicc_peer.sv
`timescale 1ns/10ps
module spicc_peer
(
  // pins toward the client port
  output logic select_in_n,
  output logic sck_in,
  output logic mosi_in
);
  // idle: deselected, clock parked low
  initial
  begin
    select_in_n = 1'b1;
    sck_in = 1'b0;
    mosi_in = 1'b0;
  end

  // mode 0 frame, msb first; clock kept well below a quarter of the core rate
  task automatic frame(input logic [15:0] bits);
    int i;
    select_in_n = 1'b0;
    for (i = 15; i >= 0; i--)
    begin
      mosi_in = bits[i];
      #200;
      sck_in = 1'b1;
      #200;
      sck_in = 1'b0;
    end
    #200;
    mosi_in = ~mosi_in; // released line must not look like held data
    select_in_n = 1'b1;
    #600;
  endtask
endmodule

// >>> spicc_ctrl_tb.sv
`timescale 1ns/10ps
module spicc_ctrl_tb
  import spicc_pkg::*;
;
  logic clock = 1'b0;
  logic core_clock = 1'b0;
  logic rst = 1'b1;
  logic core_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic write_protect = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] irq_enables;
  logic select_in_n;
  logic sck_in;
  logic mosi_in;
  logic [8:0] rx_data;
  logic rx_valid;
  logic select_wake;
  logic host_frame = 1'b0;
  logic sck_out;
  logic sck_oe;
  logic select_out_n;
  logic select_oe;
  logic sck_a;
  logic [31:0] prd_q;
  logic err_q;
  logic [31:0] last_q;
  logic [8:0] rx_seen [$];
  int wakes = 0;
  int n_fail = 0;
  int total_checks = 0;
  int i;
  int n0;
  logic [1:0] am [7] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2};
  logic [7:0] ad [7] = '{8'h5A, 8'h3C, 8'h40, 8'h42, 8'h5B, 8'h40, 8'h5B};
  logic hit [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  // bus clock, and a core clock with an unrelated phase
  always #2.5 clock = ~clock;
  initial
  begin
    #1.1;
    forever #15 core_clock = ~core_clock;
  end

  spicc_ctrl dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .write_protect(write_protect),
    .irq_enables(irq_enables), .core_clock(core_clock), .core_rst(core_rst), .select_in_n(select_in_n),
    .sck_in(sck_in), .mosi_in(mosi_in), .miso_out(), .miso_oe(), .sck_out(sck_out), .sck_oe(sck_oe),
    .select_out_n(select_out_n), .select_oe(select_oe), .host_frame(host_frame), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(1'b1),
    .tx_data(9'h000), .tx_valid(1'b0), .tx_ready(), .select_wake(select_wake));

  spicc_peer peer (.select_in_n(select_in_n), .sck_in(sck_in), .mosi_in(mosi_in));

  // answer taken at the edge that ends the access, before that edge's updates land
  always @(posedge clock)
  begin
    prd_q <= prdata;
    err_q <= pslverr;
  end

  // receive side always ready, so each valid cycle is one character
  always @(posedge core_clock)
  begin
    if (rx_valid === 1'b1)
      rx_seen.push_back(rx_data);
    if (select_wake === 1'b1)
      wakes++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one setup/access transfer; error flag compared, read data kept in last_q
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic ee);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    last_q = prd_q;
    chk({31'h0, err_q}, {31'h0, ee});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 1'b0);
    chk(last_q, exp);
  endtask

  // poll the busy register under a bounded count
  task automatic wait_sync();
    int n;
    for (n = 0; n < 40; n++)
    begin
      bus(1'b0, OFF_SYNC, 32'h0, 1'b0);
      if (last_q === 32'h0)
        return;
    end
    chk(last_q, 32'h0);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #450000;
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end

  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    core_rst <= 1'b0;
    // reset values and a hole in the map
    rd(OFF_CTRL_A, CTRL_A_RST);
    rd(OFF_CTRL_B, CTRL_B_RST);
    rd(OFF_BAUD, {24'h0, BAUD_RST});
    rd(OFF_IEN_CLR, {24'h0, IEN_RST});
    bus(1'b0, 8'h08, 32'h0, 1'b1);
    write_protect <= 1'b1;
    bus(1'b1, OFF_BAUD, 32'hA5, 1'b1);
    write_protect <= 1'b0;
    bus(1'b1, OFF_BAUD, 32'hA5, 1'b0);
    rd(OFF_BAUD, 32'hA5);
    // enable set and clear views
    bus(1'b1, OFF_IEN_SET, 32'hFF, 1'b0);
    rd(OFF_IEN_CLR, 32'h8F);
    bus(1'b1, OFF_IEN_CLR, 32'h0C, 1'b0);
    rd(OFF_IEN_SET, 32'h83);
    bus(1'b1, OFF_IEN_CLR, 32'h00, 1'b0);
    rd(OFF_IEN_CLR, 32'h83);
    wait_sync();
    bus(1'b1, OFF_MATCH, 32'h003C005A, 1'b0);
    wait_sync();
    // address matching per mode, reconfigured while disabled each time
    for (i = 0; i < 7; i++)
    begin
      bus(1'b1, OFF_CTRL_A, 32'h02000008, 1'b0);
      wait_sync();
      bus(1'b1, OFF_CTRL_B, {14'h0, 1'b1, 1'b0, am[i], 14'h2240}, 1'b0);
      rd(OFF_CTRL_B, {14'h0, 1'b1, 1'b0, am[i], 14'h2240});
      wait_sync();
      bus(1'b1, OFF_CTRL_A, 32'h0200000A, 1'b0);
      rd(OFF_CTRL_A, 32'h0200000A);
      chk({31'h0, last_q[1]}, 32'h1);
      wait_sync();
      n0 = rx_seen.size();
      peer.frame({ad[i], 8'h81});
      chk(32'(rx_seen.size()), 32'(n0 + (hit[i] ? 2 : 0)));
      if (hit[i])
      begin
        chk({23'h0, rx_seen[n0]}, {24'h0, ad[i]});
        chk({23'h0, rx_seen[n0 + 1]}, 32'h81);
      end
    end
    chk(32'(wakes), 32'd7);
    rd(OFF_FLAGS, 32'h08);
    // config is enable-protected, receiver enable is not
    bus(1'b1, OFF_BAUD, 32'h11, 1'b0);
    rd(OFF_BAUD, 32'hA5);
    bus(1'b1, OFF_CTRL_B, 32'h00006240, 1'b0);
    rd(OFF_CTRL_B, 32'h0000A240);
    rd(OFF_STATUS, 32'h0);
    bus(1'b1, OFF_CTRL_B, 32'h00026240, 1'b0);
    rd(OFF_CTRL_B, 32'h0000A240);
    bus(1'b0, OFF_SYNC, 32'h0, 1'b0);
    chk({31'h0, last_q[2]}, 32'h1);
    wait_sync();
    rd(OFF_CTRL_B, 32'h0002A240);
    // soft reset with enable in the same write
    bus(1'b1, OFF_CTRL_A, 32'h00000003, 1'b0);
    rd(OFF_CTRL_A, 32'h1);
    bus(1'b1, OFF_BAUD, 32'h33, 1'b1);
    rd(OFF_BAUD, 32'h0);
    bus(1'b0, OFF_SYNC, 32'h0, 1'b0);
    chk({31'h0, last_q[0]}, 32'h1);
    wait_sync();
    rd(OFF_CTRL_A, CTRL_A_RST);
    rd(OFF_CTRL_B, CTRL_B_RST);
    rd(OFF_BAUD, {24'h0, BAUD_RST});
    rd(OFF_IEN_SET, {24'h0, IEN_RST});
    // host mode: hardware select and divided serial clock while framing
    bus(1'b1, OFF_CTRL_B, 32'h00002000, 1'b0);
    wait_sync();
    bus(1'b1, OFF_CTRL_A, 32'h0000000E, 1'b0);
    wait_sync();
    @(posedge core_clock);
    host_frame <= 1'b1;
    repeat (3) @(posedge core_clock);
    #1;
    sck_a = sck_out;
    chk({30'h0, sck_oe, select_oe}, 32'h3);
    chk({31'h0, select_out_n}, 32'h0);
    @(posedge core_clock);
    #1;
    chk({31'h0, sck_a ^ sck_out}, 32'h1);
    @(posedge core_clock);
    host_frame <= 1'b0;
    repeat (2) @(posedge core_clock);
    #1;
    chk({31'h0, select_out_n}, 32'h1);
    close_out();
  end
endmodule
